// >>> design/lcp_level_compander.sv
// Two-channel level compander with AHB-Lite coefficient registers.
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module lcp_level_compander
    import lcp_pkg::*;
(
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      arst_n,
    // AHB-Lite slave
    input  wire logic                      hsel,
    input  wire logic [7:0]                haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // Audio stream in
    input  wire logic                      sampleValid,
    input  wire logic [lcp_pkg::IN_W-1:0]  sampleCh0,
    input  wire logic [lcp_pkg::IN_W-1:0]  sampleCh1,
    // Audio stream out
    output logic                           outValid,
    output logic      [lcp_pkg::IN_W-1:0]  outCh0,
    output logic      [lcp_pkg::IN_W-1:0]  outCh1
);
    import lcp_pkg::*;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Signed 48x28 product rescaled by 2^-23 back to 48 bits.
    function automatic logic signed [WORD_W-1:0] fmul(input logic signed [WORD_W-1:0] a,
                                                      input logic signed [COEF_W-1:0] b);
        logic signed [WORD_W+COEF_W-1:0] p;
        p = a * b;
        return p[FRAC_W +: WORD_W];
    endfunction

    // First-order smoother: w*x + wc*y.
    function automatic logic signed [WORD_W-1:0] smooth(input logic signed [WORD_W-1:0] x,
                                                        input logic signed [WORD_W-1:0] y,
                                                        input logic signed [COEF_W-1:0] w,
                                                        input logic signed [COEF_W-1:0] wc);
        return fmul(x, w) + fmul(y, wc);
    endfunction

    // Log2 of a positive 25.23 value, result in 25.23, with linear mantissa.
    function automatic logic signed [WORD_W-1:0] log2fx(input logic [WORD_W-1:0] v);
        logic [5:0]        msb;
        logic [WORD_W-1:0] norm;
        msb  = 6'd0;
        for (int i = 0; i < WORD_W; i++) begin
            if (v[i]) msb = 6'(i);
        end
        norm = v << (6'd47 - msb);
        return {{(WORD_W-FRAC_W-6){1'b0}}, msb, 23'd0} - {19'd0, 6'd23, 23'd0}
             + {25'd0, norm[46:24]};
    endfunction

    // Two to the power of a 25.23 log value, as a saturated 5.23 gain.
    function automatic logic [COEF_W-1:0] exp2fx(input logic signed [WORD_W-1:0] l);
        logic signed [WORD_W-FRAC_W-1:0] ip;
        logic [COEF_W+16-1:0]            mant;
        ip   = l[WORD_W-1:FRAC_W];
        mant = {20'd0, 1'b1, l[FRAC_W-1:0]};
        if (ip > 25'sd3) return 28'h7ffffff;
        if (ip < -25'sd24) return 28'h0000000;
        if (ip >= 0) mant = mant << ip[4:0];
        else mant = mant >> 5'((-ip));
        return mant[COEF_W-1:0];
    endfunction

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [WORD_W-1:0]  lowerThreshold_reg, upperThreshold_reg;
    logic [WORD_W-1:0]  lowerOffset_reg, upperOffset_reg;
    logic [SLOPE_W-1:0] lowSlope_reg, midSlope_reg, highSlope_reg;
    logic [COEF_W-1:0]  energyW_reg, energyWc_reg, attackW_reg, attackWc_reg;
    logic [COEF_W-1:0]  decayW_reg, decayWc_reg, mix0_reg, mix1_reg;
    logic               enable_reg;
    logic               wrPend_reg, rdPend_reg;
    logic [7:0]         addr_reg;

    // -------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // -------------------------------------------------------------------
    wire addrTake = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addr_reg   <= 8'h00;
        end else begin
            wrPend_reg <= addrTake && hwrite;
            rdPend_reg <= addrTake && !hwrite;
            if (addrTake) addr_reg <= haddr;
        end
    end

    wire [31:0] w = hwdata;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            enable_reg <= 1'b0;
            lowerThreshold_reg <= RST_LTH;
            upperThreshold_reg <= RST_UTH;
            lowerOffset_reg <= RST_OFS;
            upperOffset_reg <= RST_OFS;
            lowSlope_reg <= RST_SLOPE;
            midSlope_reg <= RST_SLOPE;
            highSlope_reg <= RST_SLOPE;
            energyW_reg <= RST_WEIGHT;
            energyWc_reg <= RST_WEIGHTC;
            attackW_reg <= RST_WEIGHT;
            attackWc_reg <= RST_WEIGHTC;
            decayW_reg <= RST_WEIGHT;
            decayWc_reg <= RST_WEIGHTC;
            mix0_reg <= RST_MIX;
            mix1_reg <= RST_MIX;
        end else if (wrPend_reg) begin
            unique case (addr_reg)
                REG_CTRL:    enable_reg <= w[0];
                REG_LTH_LO:  lowerThreshold_reg[31:0] <= w;
                REG_LTH_HI:  lowerThreshold_reg[47:32] <= w[15:0];
                REG_UTH_LO:  upperThreshold_reg[31:0] <= w;
                REG_UTH_HI:  upperThreshold_reg[47:32] <= w[15:0];
                REG_LOFS_LO: lowerOffset_reg[31:0] <= w;
                REG_LOFS_HI: lowerOffset_reg[47:32] <= w[15:0];
                REG_UOFS_LO: upperOffset_reg[31:0] <= w;
                REG_UOFS_HI: upperOffset_reg[47:32] <= w[15:0];
                REG_K0:      lowSlope_reg <= w[27:0];
                REG_K1:      midSlope_reg <= w[27:0];
                REG_K2:      highSlope_reg <= w[27:0];
                REG_EW:      energyW_reg <= w[27:0];
                REG_EWC:     energyWc_reg <= w[27:0];
                REG_AW:      attackW_reg <= w[27:0];
                REG_AWC:     attackWc_reg <= w[27:0];
                REG_DW:      decayW_reg <= w[27:0];
                REG_DWC:     decayWc_reg <= w[27:0];
                REG_MIX0:    mix0_reg <= w[27:0];
                REG_MIX1:    mix1_reg <= w[27:0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Processing pipeline
    // -------------------------------------------------------------------
    logic signed [WORD_W-1:0] rms0_reg, rms1_reg, gain_reg;
    logic [COEF_W-1:0]        target_reg;
    logic [1:0]               stage_reg;
    lcp_region_t              region_reg;
    logic signed [WORD_W-1:0] aud0_reg, aud1_reg;

    // Inputs sit in the top 32 bits, then the programmable mixer scales them.
    wire signed [WORD_W-1:0] word0 = {sampleCh0, 16'h0000};
    wire signed [WORD_W-1:0] word1 = {sampleCh1, 16'h0000};
    wire signed [WORD_W-1:0] mixed0 = fmul(word0, mix0_reg);
    wire signed [WORD_W-1:0] mixed1 = fmul(word1, mix1_reg);
    // Energy of the scaled sample; squaring in 25.23 keeps small levels small.
    wire signed [WORD_W-1:0] sq0 = fmul(mixed0, mixed0[WORD_W-1 -: COEF_W]);
    wire signed [WORD_W-1:0] sq1 = fmul(mixed1, mixed1[WORD_W-1 -: COEF_W]);
    wire signed [WORD_W-1:0] rms0Next = smooth(sq0, rms0_reg, energyW_reg, energyWc_reg);
    wire signed [WORD_W-1:0] rms1Next = smooth(sq1, rms1_reg, energyW_reg, energyWc_reg);
    wire signed [WORD_W-1:0] rmsMax = (rms0_reg > rms1_reg) ? rms0_reg : rms1_reg;

    // Log level is non-positive; thresholds are stored as positive multiples of -6.0206 dB.
    wire signed [WORD_W-1:0] levelLog = log2fx(rmsMax);
    wire signed [WORD_W-1:0] upperLog = -$signed(upperThreshold_reg);
    wire signed [WORD_W-1:0] lowerLog = -$signed(lowerThreshold_reg);
    wire isHigh = levelLog >= upperLog;
    wire isMid  = !isHigh && (levelLog >= lowerLog);
    wire signed [WORD_W-1:0] distUpper = levelLog - upperLog;
    wire signed [WORD_W-1:0] distLower = levelLog - lowerLog;
    wire signed [WORD_W-1:0] curveHigh = fmul(distUpper, highSlope_reg) - $signed(upperOffset_reg);
    wire signed [WORD_W-1:0] curveMid  = fmul(distUpper, midSlope_reg) - $signed(upperOffset_reg);
    wire signed [WORD_W-1:0] curveLow  = fmul(distLower, lowSlope_reg) - $signed(lowerOffset_reg);
    wire signed [WORD_W-1:0] curveLog  = isHigh ? curveHigh : (isMid ? curveMid : curveLow);
    // Remove the bias so a zero-dB offset gives exact unity.
    wire [COEF_W-1:0] targetNext = exp2fx(curveLog + $signed(OFFSET_BIAS));
    wire lcp_region_t regionNext = isHigh ? REGION_HIGH : (isMid ? REGION_MID : REGION_LOW);

    wire signed [WORD_W-1:0] targetWide = {20'h00000, target_reg};
    wire cut = targetWide < gain_reg;
    wire signed [WORD_W-1:0] gainNext = cut ? smooth(targetWide, gain_reg, attackW_reg, attackWc_reg)
                                            : smooth(targetWide, gain_reg, decayW_reg, decayWc_reg);
    wire [COEF_W-1:0] gainCoef = gain_reg[COEF_W-1:0];

    // Three stages run back to back, one per cycle after each sample.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rms0_reg   <= '0;
            rms1_reg   <= '0;
            gain_reg   <= {20'h00000, UNITY};
            target_reg <= UNITY;
            region_reg <= REGION_HIGH;
            stage_reg  <= 2'd0;
            aud0_reg   <= '0;
            aud1_reg   <= '0;
        end else begin
            stage_reg <= {stage_reg[0], sampleValid && enable_reg};
            if (sampleValid && enable_reg) begin
                rms0_reg <= rms0Next;
                rms1_reg <= rms1Next;
                aud0_reg <= mixed0;
                aud1_reg <= mixed1;
            end
            if (stage_reg[0]) begin
                target_reg <= targetNext;
                region_reg <= regionNext;
            end
            if (stage_reg[1]) gain_reg <= gainNext;
        end
    end

    // Output mixer applies the gain to the held samples.
    wire signed [WORD_W-1:0] prod0 = fmul(aud0_reg, gainCoef);
    wire signed [WORD_W-1:0] prod1 = fmul(aud1_reg, gainCoef);
    logic outValid_reg;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            outValid_reg <= 1'b0;
            outCh0 <= '0;
            outCh1 <= '0;
        end else begin
            outValid_reg <= stage_reg[1];
            if (stage_reg[1]) begin
                outCh0 <= prod0[WORD_W-1 -: IN_W];
                outCh1 <= prod1[WORD_W-1 -: IN_W];
            end
        end
    end
    assign outValid = outValid_reg;

    // Read mux.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) hrdata <= 32'h00000000;
        else if (addrTake && !hwrite) begin
            unique case (haddr)
                REG_CTRL:   hrdata <= {31'd0, enable_reg};
                REG_STATUS: hrdata <= {30'd0, region_reg};
                REG_K0:     hrdata <= {4'h0, lowSlope_reg};
                REG_K1:     hrdata <= {4'h0, midSlope_reg};
                REG_K2:     hrdata <= {4'h0, highSlope_reg};
                REG_MIX0:   hrdata <= {4'h0, mix0_reg};
                REG_MIX1:   hrdata <= {4'h0, mix1_reg};
                REG_GAIN:   hrdata <= {4'h0, gainCoef};
                default:    hrdata <= 32'h00000000;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    pipe_order_a: assert property (sampleValid && enable_reg |-> ##2 stage_reg[1] ##1 outValid)
        else $error("pipeline stage order broken");
    max_select_a: assert property (stage_reg[0] |-> (rmsMax >= rms0_reg && rmsMax >= rms1_reg))
        else $error("rms maximum not selected");
    region_high_a: assert property (stage_reg[0] && isHigh |=> region_reg == REGION_HIGH)
        else $error("high region not recorded");
    region_low_a: assert property (stage_reg[0] && levelLog < lowerLog && lowerLog <= upperLog
                                   |=> region_reg == REGION_LOW)
        else $error("low region not recorded");
    unity_pivot_a: assert property (stage_reg[0] && levelLog == upperLog && upperOffset_reg == OFFSET_BIAS
                                    |=> target_reg == UNITY)
        else $error("unity gain missing at pivot");
    attack_dir_a: assert property (stage_reg[1] && cut |=> gain_reg <= $past(gain_reg))
        else $error("attack raised the gain");
    rms_hold_a: assert property (!(sampleValid && enable_reg) |=> $stable(rms0_reg) && $stable(rms1_reg))
        else $error("rms changed without a sample");
    sat_range_a: assert property (target_reg[COEF_W-1] == 1'b0 || target_reg == 28'h7ffffff)
        else $error("target gain out of range");
    out_hold_a: assert property (!stage_reg[1] |=> $stable(outCh0))
        else $error("output changed without a gain step");

    cov_high_c: cover property (stage_reg[0] && isHigh);
    cov_mid_c:  cover property (stage_reg[0] && isMid);
    cov_low_c:  cover property (stage_reg[0] && !isHigh && !isMid);
    cov_cut_c:  cover property (stage_reg[1] && cut);

endmodule

// >>> design/lcp_pkg.sv
// Shared constants of the level compander: formats, bus map, reset values.
package lcp_pkg;

    // -------------------------------------------------------------------
    // Number formats
    // -------------------------------------------------------------------
    localparam int WORD_W  = 48;
    localparam int FRAC_W  = 23;
    localparam int SLOPE_W = 28;
    localparam int COEF_W  = 28;
    localparam int IN_W    = 32;
    localparam logic [COEF_W-1:0] UNITY = 28'h0800000;
    // Offset bias of 24.0824 dB, which is exactly 4.0 in log2 units (6.0206 dB each).
    localparam logic [WORD_W-1:0] OFFSET_BIAS = 48'h000002000000;

    // -------------------------------------------------------------------
    // Register byte addresses
    // -------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_LTH_LO  = 8'h08;
    localparam logic [7:0] REG_LTH_HI  = 8'h0c;
    localparam logic [7:0] REG_UTH_LO  = 8'h10;
    localparam logic [7:0] REG_UTH_HI  = 8'h14;
    localparam logic [7:0] REG_LOFS_LO = 8'h18;
    localparam logic [7:0] REG_LOFS_HI = 8'h1c;
    localparam logic [7:0] REG_UOFS_LO = 8'h20;
    localparam logic [7:0] REG_UOFS_HI = 8'h24;
    localparam logic [7:0] REG_K0      = 8'h28;
    localparam logic [7:0] REG_K1      = 8'h2c;
    localparam logic [7:0] REG_K2      = 8'h30;
    localparam logic [7:0] REG_EW      = 8'h34;
    localparam logic [7:0] REG_EWC     = 8'h38;
    localparam logic [7:0] REG_AW      = 8'h3c;
    localparam logic [7:0] REG_AWC     = 8'h40;
    localparam logic [7:0] REG_DW      = 8'h44;
    localparam logic [7:0] REG_DWC     = 8'h48;
    localparam logic [7:0] REG_MIX0    = 8'h4c;
    localparam logic [7:0] REG_MIX1    = 8'h50;
    localparam logic [7:0] REG_GAIN    = 8'h54;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [COEF_W-1:0] RST_WEIGHT  = 28'h000883f;
    localparam logic [COEF_W-1:0] RST_WEIGHTC = 28'h07f77c0;
    localparam logic [SLOPE_W-1:0] RST_SLOPE  = 28'h0000000;
    localparam logic [WORD_W-1:0] RST_UTH     = 48'h000001000000;
    localparam logic [WORD_W-1:0] RST_LTH     = 48'h000004000000;
    localparam logic [WORD_W-1:0] RST_OFS     = OFFSET_BIAS;
    localparam logic [COEF_W-1:0] RST_MIX     = UNITY;

    // Region codes.
    typedef enum logic [1:0] {
        REGION_LOW  = 2'b00,
        REGION_MID  = 2'b01,
        REGION_HIGH = 2'b10
    } lcp_region_t;

endpackage

// >>> tb/lcp_sample_source.sv
// Upstream pipeline model: square-wave stereo sample pairs for the compander.
`timescale 1ns/1ps
module lcp_sample_source (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // Control from the bench
    input  wire logic        run,
    input  wire logic [31:0] amp0,
    input  wire logic [31:0] amp1,
    // Sample stream
    output logic             sampleValid,
    output logic      [31:0] sampleCh0,
    output logic      [31:0] sampleCh1
);
    logic [1:0] gapReg;
    logic       signReg;
    wire        fire = run && (gapReg == 2'h3);
    // Between pulses the lines invert every cycle, alternating the inverse and the last value.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gapReg      <= 2'h0;
            signReg     <= 1'b0;
            sampleValid <= 1'b0;
            sampleCh0   <= 32'h0;
            sampleCh1   <= 32'h0;
        end else begin
            gapReg      <= gapReg + 2'h1;
            sampleValid <= fire;
            if (fire) begin
                signReg   <= ~signReg;
                sampleCh0 <= signReg ? -amp0 : amp0;
                sampleCh1 <= signReg ? -amp1 : amp1;
            end else begin
                sampleCh0 <= ~sampleCh0;
                sampleCh1 <= ~sampleCh1;
            end
        end
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench of the level compander: bus programming, regions, gain and stream.
`timescale 1ns/1ps
module tb_top;
    import lcp_pkg::*;
    logic        clock = 0, arst_n = 0, hsel = 0, hwrite = 0, run = 0;
    logic [7:0]  haddr = 8'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, amp0 = 32'h0, amp1 = 32'h0, rdv, inHist;
    logic [31:0] hrdata, outCh0, outCh1, sampleCh0, sampleCh1;
    logic        hreadyout, hresp, outValid, sampleValid;
    int          n_errors = 0, n_checks = 0;

    always #4 clock = ~clock;
    always @(posedge clock) if (sampleValid) inHist <= sampleCh1;

    lcp_level_compander dut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sampleValid(sampleValid), .sampleCh0(sampleCh0),
        .sampleCh1(sampleCh1), .outValid(outValid), .outCh0(outCh0), .outCh1(outCh1));
    lcp_sample_source src (.clock(clock), .arst_n(arst_n), .run(run), .amp0(amp0), .amp1(amp1),
        .sampleValid(sampleValid), .sampleCh0(sampleCh0), .sampleCh1(sampleCh1));

    // -------------------------------------------------------------------
    // Reporting
    // -------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // -------------------------------------------------------------------
    // AHB-Lite master
    // -------------------------------------------------------------------
    task automatic waitReady();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            give_verdict();
        end
        rdv = hrdata;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        waitReady();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitReady();
    endtask
    task automatic wr48(input logic [7:0] a, input logic [47:0] v);
        xfer(1'b1, a, v[31:0]);
        xfer(1'b1, a + 8'h4, {16'h0, v[47:32]});
    endtask
    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(what, exp, rdv);
    endtask

    // -------------------------------------------------------------------
    // Stream helpers
    // -------------------------------------------------------------------
    task automatic waitOut(input int n);
        int i;
        for (i = 0; i < 40 * n && n > 0; i++) begin
            @(negedge clock);
            if (outValid === 1'b1) n--;
        end
        if (n != 0) begin
            n_errors++;
            give_verdict();
        end
        @(posedge clock);
    endtask
    // Shift -1 halves, 0 keeps, 1 doubles the last ch1 input; amplitudes keep this exact.
    task automatic checkOut(input int sh, input logic [27:0] g);
        logic signed [31:0] expOut;
        waitOut(6);
        expOut = inHist;
        if (sh < 0) expOut = expOut >>> 1;
        if (sh > 0) expOut = expOut <<< 1;
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("outCh1", expOut, outCh1);
        chk("outCh0", 32'h0, outCh0);
        @(posedge clock);
        rdChk("gainReg", REG_GAIN, {4'h0, g});
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_reset_values();
        rdChk("ctrl", REG_CTRL, 32'h0);
        rdChk("mix0", REG_MIX0, {4'h0, RST_MIX});
        rdChk("unmapped", 8'h7c, 32'h0);
    endtask
    task automatic t_setup();
        wr48(REG_UTH_LO, 48'h00000a000000);
        wr48(REG_LTH_LO, 48'h00000b000000);
        xfer(1'b1, REG_EW, {4'h0, UNITY});
        xfer(1'b1, REG_EWC, 32'h0);
        xfer(1'b1, REG_AW, {4'h0, UNITY});
        xfer(1'b1, REG_AWC, 32'h0);
        xfer(1'b1, REG_DW, {4'h0, UNITY});
        xfer(1'b1, REG_DWC, 32'h0);
    endtask
    task automatic t_disabled();
        int i, seen;
        seen = 0;
        run <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clock);
            if (outValid !== 1'b0) seen++;
        end
        chk("outValidOff", 32'h0, seen);
        @(posedge clock);
    endtask
    task automatic t_regions_unity();
        xfer(1'b1, REG_CTRL, 32'h1);
        waitOut(4);
        rdChk("statusLow", REG_STATUS, {30'h0, REGION_LOW});
        amp1 <= 32'h00000080;
        waitOut(4);
        rdChk("statusHigh", REG_STATUS, {30'h0, REGION_HIGH});
        xfer(1'b1, REG_GAIN, 32'h0);
        checkOut(0, UNITY);
    endtask
    task automatic t_offsets();
        wr48(REG_UOFS_LO, OFFSET_BIAS + 48'h800000);
        checkOut(-1, UNITY >> 1);
        wr48(REG_UOFS_LO, OFFSET_BIAS - 48'h800000);
        checkOut(1, UNITY << 1);
    endtask
    task automatic t_attack_hold();
        xfer(1'b1, REG_AW, 32'h0);
        xfer(1'b1, REG_AWC, {4'h0, UNITY});
        wr48(REG_UOFS_LO, OFFSET_BIAS + 48'h800000);
        checkOut(1, UNITY << 1);
        xfer(1'b1, REG_AWC, 32'h0);
        xfer(1'b1, REG_AW, {4'h0, UNITY});
        checkOut(-1, UNITY >> 1);
    endtask
    task automatic t_mid();
        wr48(REG_UTH_LO, 48'h000000000001);
        waitOut(4);
        rdChk("statusMid", REG_STATUS, {30'h0, REGION_MID});
        xfer(1'b1, REG_CTRL, 32'h0);
        repeat (4) @(posedge clock);
        t_disabled();
    endtask

    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        t_reset_values();
        t_setup();
        t_disabled();
        t_regions_unity();
        t_offsets();
        t_attack_hold();
        t_mid();
        give_verdict();
    end
endmodule
